// [ogr_pkg.sv]
// Shared constants for the unique-ID, ROM map and failed-write register bank
package ogr_pkg;
    localparam logic [7:0]  ADDR_UID_UPPER    = 8'h24;
    localparam logic [7:0]  ADDR_UID_LOWER    = 8'h28;
    localparam logic [7:0]  ADDR_ROM_MAP_BASE = 8'h34;
    localparam logic [7:0]  ADDR_FAIL_OFF_LOW = 8'h38;
    localparam logic [7:0]  ADDR_FAIL_SRC_HI  = 8'h3c;
    localparam logic [7:0]  ADDR_MAKER_ID     = 8'h40;
    localparam logic [7:0]  ADDR_ID_STATUS    = 8'h44;
    localparam logic [31:0] UID_RESET         = 32'h0000_0000;
    localparam logic [31:0] ROM_MAP_RESET     = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
    localparam int          ROM_BASE_LSB      = 10;
    localparam int          ROM_OFF_BITS      = 10;
    localparam int          BUS_NUM_LSB       = 22;
    localparam int          NODE_NUM_LSB      = 16;
    localparam int          OFF_HIGH_LSB      = 0;
    localparam int          STAT_LOCKED_BIT   = 0;
    localparam int          STAT_EEPROM_BIT   = 1;
    localparam int          STAT_CAPTURED_BIT = 2;
    // ROM window: offsets 0xFFFF_F000_0400 .. 0xFFFF_F000_07FF
    localparam logic [47:0] ROM_WIN_LOW       = 48'hffff_f000_0400;
    localparam logic [47:0] ROM_WIN_HIGH      = 48'hffff_f000_07ff;
    typedef enum logic [1:0] {OGR_ID_EMPTY, OGR_ID_LOCKED} ogr_id_state_t;
endpackage : ogr_pkg

// [ogr_id_lock.sv]
// Write-once holder of the 64-bit node unique ID
`timescale 1ns/100ps
module ogr_id_lock
(
    input  wire logic        mclk,
    input  wire logic        clear_n,
    input  wire logic        load_valid,
    input  wire logic [63:0] load_data,
    output logic      [63:0] id_value,
    output logic             locked
);
    ogr_pkg::ogr_id_state_t state;
    ogr_pkg::ogr_id_state_t next_state;
    logic                   take_load;

    // A load is accepted only while still empty; later loads are dropped
    assign take_load = load_valid && (state == ogr_pkg::OGR_ID_EMPTY);
    assign locked    = (state == ogr_pkg::OGR_ID_LOCKED);

    // One load moves the holder into the locked state for good
    always_comb
    begin
        next_state = state;
        case (state)
            ogr_pkg::OGR_ID_EMPTY:
            begin
                if (load_valid)
                    next_state = ogr_pkg::OGR_ID_LOCKED;
            end
            default:
                next_state = ogr_pkg::OGR_ID_LOCKED;
        endcase
    end

    // Cleared by every reset source
    always_ff @(posedge mclk)
    begin
        if (!clear_n)
        begin
            state    <= ogr_pkg::OGR_ID_EMPTY;
            id_value <= {ogr_pkg::UID_RESET, ogr_pkg::UID_RESET};
        end
        else
        begin
            state <= next_state;
            if (take_load)
                id_value <= load_data;
        end
    end

    id_frozen_a: assert property (@(posedge mclk) disable iff (!clear_n)
        locked |=> (id_value == $past(id_value)))
        else $error("unique ID changed after lock");
endmodule : ogr_id_lock

// [ogr_rom_xlate.sv]
// Maps 1394 ROM window quadlet reads onto host memory addresses
`timescale 1ns/100ps
module ogr_rom_xlate
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        rd_valid,
    input  wire logic [47:0] rd_offset,
    input  wire logic [31:0] base,
    output logic             host_valid,
    output logic      [31:0] host_addr
);
    logic        in_window;
    logic [31:0] sum_addr;

    // Window check and base plus low ten offset bits
    assign in_window = (rd_offset >= ogr_pkg::ROM_WIN_LOW)
                    && (rd_offset <= ogr_pkg::ROM_WIN_HIGH);
    assign sum_addr  = base + {22'h0,
                       rd_offset[ogr_pkg::ROM_OFF_BITS-1:0]};

    // Registered so the host address is a flip-flop output
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            host_valid <= 1'b0;
            host_addr  <= 32'h0000_0000;
        end
        else
        begin
            host_valid <= rd_valid && in_window;
            if (rd_valid && in_window)
                host_addr <= sum_addr;
        end
    end

    xlate_sum_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_valid && in_window) |=> host_valid
            && host_addr == $past(base) + {22'h0, $past(rd_offset[9:0])})
        else $error("ROM address not base plus low offset");
endmodule : ogr_rom_xlate

// [ogr_regs.sv]
// Unique-ID, ROM mapping, failed-write and maker identity registers
//
// What this block does
// - Both unique-ID registers clear to zero on hardware reset, meaning invalid.
// - With EEPROM present, ID loads via EEPROM port then stays locked.
// - Without EEPROM, firmware loads the ID once; then it stays locked.
// - Fundamental, global and power-on reset all clear the unique ID.
// - Upper ID register shows the top 32 bits of the node ID.
// - Lower ID register shows bottom 32 bits, same load and lock.
// - ROM window quadlet reads map to base plus low ten offset bits.
// - ROM map base bits 31:10 read/write, bits 9:0 read zero.
// - A failed posted write records its details in the error registers.
// - Low error register holds destination offset bits 31:0.
// - High error register bits 31:22 bus number, 21:16 node number.
// - High error register bits 15:0 hold destination offset bits 47:32.
// - Error registers are undefined after reset until a capture occurs.
// - Maker identity is read-only, fixed; writes are ignored.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
module ogr_regs
#(
    // Arbitrary neutral identity value, not any real organisation code
    parameter logic [31:0] MAKER_CODE = 32'h0012_3456
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        pcie_reset_n,
    input  wire logic        global_reset_input_n,
    input  wire logic        por_n,
    input  wire logic        eeprom_present,
    input  wire logic        eeprom_id_valid,
    input  wire logic [63:0] eeprom_id_data,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rom_rd_valid,
    input  wire logic [47:0] rom_rd_offset,
    output logic             rom_host_valid,
    output logic      [31:0] rom_host_addr,
    input  wire logic        post_fail,
    input  wire logic [47:0] post_fail_offset,
    input  wire logic [15:0] post_fail_source
);
    ////////////////////////////////////////////////////////////////////////
    // Reset source and EEPROM-present synchronisers (pins from outside this clock domain)
    logic [1:0] pcie_sync;
    logic [1:0] global_reset_input_sync;
    logic [1:0] por_sync;
    logic [1:0] eep_sync;
    logic       id_clear_n;

    // Two flops each before any logic sees the pin levels
    always_ff @(posedge mclk)
    begin
        pcie_sync <= {pcie_sync[0], pcie_reset_n};
        global_reset_input_sync <= {global_reset_input_sync[0], global_reset_input_n};
        por_sync  <= {por_sync[0], por_n};
        eep_sync  <= {eep_sync[0], eeprom_present};
    end

    // Any one reset source clears the ID holder
    assign id_clear_n = rst_n && pcie_sync[1] && global_reset_input_sync[1]
                     && por_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic        sel_upper;
    logic        sel_lower;
    logic        sel_rom;
    logic        sel_off_low;
    logic        sel_src_hi;
    logic        sel_maker;
    logic        sel_status;
    logic        wr_upper;
    logic        wr_lower;
    logic        wr_rom;
    logic        ack;

    // One wait state: answer comes at the second edge of the request
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    assign sel_upper   = (avs_address == ogr_pkg::ADDR_UID_UPPER);
    assign sel_lower   = (avs_address == ogr_pkg::ADDR_UID_LOWER);
    assign sel_rom     = (avs_address == ogr_pkg::ADDR_ROM_MAP_BASE);
    assign sel_off_low = (avs_address == ogr_pkg::ADDR_FAIL_OFF_LOW);
    assign sel_src_hi  = (avs_address == ogr_pkg::ADDR_FAIL_SRC_HI);
    assign sel_maker   = (avs_address == ogr_pkg::ADDR_MAKER_ID);
    assign sel_status  = (avs_address == ogr_pkg::ADDR_ID_STATUS);

    // Writes count only at the accepting edge
    assign wr_upper = avs_write && !avs_waitrequest && sel_upper;
    assign wr_lower = avs_write && !avs_waitrequest && sel_lower;
    assign wr_rom   = avs_write && !avs_waitrequest && sel_rom;

    ////////////////////////////////////////////////////////////////////////
    // Unique ID: firmware stages two halves, the upper write commits both
    logic [31:0] fw_lower_stage;
    logic        fw_load;
    logic        eep_load;
    logic        id_load;
    logic [63:0] id_load_data;
    logic [63:0] id_value;
    logic        id_locked;

    // EEPROM path only when present, firmware path only when absent
    assign eep_load     = eep_sync[1] && eeprom_id_valid;
    assign fw_load      = !eep_sync[1] && wr_upper;
    assign id_load      = eep_load || fw_load;
    assign id_load_data = eep_load ? eeprom_id_data
                                   : {avs_writedata, fw_lower_stage};

    // Lower half staged so the pair locks atomically
    always_ff @(posedge mclk)
    begin
        if (!id_clear_n)
            fw_lower_stage <= ogr_pkg::UID_RESET;
        else if (wr_lower && !id_locked)
            fw_lower_stage <= avs_writedata;
    end

    ogr_id_lock u_id_lock
    (
        .mclk       (mclk),
        .clear_n    (id_clear_n),
        .load_valid (id_load),
        .load_data  (id_load_data),
        .id_value   (id_value),
        .locked     (id_locked)
    );

    ////////////////////////////////////////////////////////////////////////
    // ROM map base and translation
    logic [31:0] rom_base;

    // Low ten bits never stored, so they always read zero
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rom_base <= ogr_pkg::ROM_MAP_RESET;
        else if (wr_rom)
            rom_base <= {avs_writedata[31:ogr_pkg::ROM_BASE_LSB],
                         10'h000};
    end

    ogr_rom_xlate u_rom_xlate
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rd_valid   (rom_rd_valid),
        .rd_offset  (rom_rd_offset),
        .base       (rom_base),
        .host_valid (rom_host_valid),
        .host_addr  (rom_host_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Failed posted-write capture
    logic [31:0] fail_off_low;
    logic [31:0] fail_src_high;
    logic        captured;

    // Contents not reset: meaningless until the first capture
    always_ff @(posedge mclk)
    begin
        if (post_fail)
        begin
            fail_off_low  <= post_fail_offset[31:0];
            fail_src_high <= {post_fail_source,
                              post_fail_offset[47:32]};
        end
    end

    // Capture flag lets software know the pair is trustworthy
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            captured <= 1'b0;
        else if (post_fail)
            captured <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge
    logic [31:0] next_readdata;
    logic [31:0] status_word;

    assign status_word = {29'h0, captured, eep_sync[1], id_locked};

    // Unmapped addresses read zero; writes there are dropped
    assign next_readdata =
          sel_upper   ? id_value[63:32]
        : sel_lower   ? id_value[31:0]
        : sel_rom     ? rom_base
        : sel_off_low ? fail_off_low
        : sel_src_hi  ? fail_src_high
        : sel_maker   ? MAKER_CODE
        : sel_status  ? status_word
        : ogr_pkg::UNMAPPED_READ;

    // Ack pulses one cycle after the request rises
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= (avs_read || avs_write) && !ack;
            if (avs_read && !ack)
                avs_readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    rom_low_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rom_base[9:0] == 10'h000)
        else $error("ROM base low bits not zero");

    rom_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_rom |=> rom_base[31:10] == $past(avs_writedata[31:10]))
        else $error("ROM base write lost");

    id_clear_a: assert property (@(posedge mclk)
        !id_clear_n |=> id_value == 64'h0 && !id_locked)
        else $error("unique ID not cleared by reset");

    fw_lock_a: assert property (@(posedge mclk) disable iff (!id_clear_n)
        (id_locked && wr_upper) |=> id_value == $past(id_value))
        else $error("firmware changed locked ID");

    eep_load_a: assert property (@(posedge mclk) disable iff (!id_clear_n)
        (eep_load && !id_locked) |=> id_locked
            && id_value == $past(eeprom_id_data))
        else $error("EEPROM ID not loaded");

    pair_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        post_fail |=> fail_off_low == $past(post_fail_offset[31:0])
            && fail_src_high == {$past(post_fail_source),
                                 $past(post_fail_offset[47:32])})
        else $error("failed write pair not captured together");

    cap_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        post_fail |=> captured)
        else $error("capture flag not set");

    maker_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_read && !ack && sel_maker) |=> avs_readdata == MAKER_CODE)
        else $error("maker identity wrong");

    upper_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_read && !ack && sel_upper) |=> avs_readdata == id_value[63:32])
        else $error("upper ID read wrong");
endmodule : ogr_regs

// [ogr_remote_node.sv]
// Far-side stand-in: remote 1394 requester, posted-write failures, EEPROM
`timescale 1ns/100ps
module ogr_remote_node
(
    input  wire logic        mclk,
    output logic             rom_rd_valid,
    output logic      [47:0] rom_rd_offset,
    output logic             post_fail,
    output logic      [47:0] post_fail_offset,
    output logic      [15:0] post_fail_source,
    output logic             eeprom_id_valid,
    output logic      [63:0] eeprom_id_data
);
    ////////////////////////////////////////////////////////////////////////
    // Idle fields carry junk, never a stale copy that could pass for data
    initial
    begin
        rom_rd_valid     = 1'b0;
        rom_rd_offset    = 48'h5a5a_5a5a_5a5a;
        post_fail        = 1'b0;
        post_fail_offset = 48'ha5a5_a5a5_a5a5;
        post_fail_source = 16'h5a5a;
        eeprom_id_valid  = 1'b0;
        eeprom_id_data   = 64'ha5a5_a5a5_a5a5_a5a5;
    end

    ////////////////////////////////////////////////////////////////////////
    // One quadlet read, held for exactly one edge
    task automatic rom_read(input logic [47:0] off);
        @(posedge mclk);
        rom_rd_valid  <= 1'b1;
        rom_rd_offset <= off;
        @(posedge mclk);
        rom_rd_valid  <= 1'b0;
        rom_rd_offset <= ~off;
    endtask : rom_read

    // Data phase of an already acknowledged write goes wrong
    task automatic fail_write(input logic [47:0] off,
                              input logic [15:0] src);
        @(posedge mclk);
        post_fail        <= 1'b1;
        post_fail_offset <= off;
        post_fail_source <= src;
        @(posedge mclk);
        post_fail        <= 1'b0;
        post_fail_offset <= ~off;
        post_fail_source <= ~src;
    endtask : fail_write

    // Serial EEPROM finishes fetching the node ID
    task automatic eeprom_load(input logic [63:0] id);
        @(posedge mclk);
        eeprom_id_valid <= 1'b1;
        eeprom_id_data  <= id;
        @(posedge mclk);
        eeprom_id_valid <= 1'b0;
        eeprom_id_data  <= ~id;
    endtask : eeprom_load
endmodule : ogr_remote_node

// [ogr_regs_tb.sv]
// Self-checking bench for the unique-ID, ROM map and failed-write registers
`timescale 1ns/100ps
module ogr_regs_tb;
    // Arbitrary maker value, deliberately not the ogr_regs MAKER_CODE default
    localparam logic [31:0] MAKER_VAL = 32'h00a5_5a00;
    logic        mclk                 = 1'b0;
    logic        rst_n                = 1'b0;
    logic        pcie_reset_n         = 1'b1;
    logic        global_reset_input_n = 1'b1;
    logic        por_n                = 1'b1;
    logic        eeprom_present       = 1'b0;
    logic [7:0]  avs_address          = 8'h00;
    logic        avs_read             = 1'b0;
    logic        avs_write            = 1'b0;
    logic [31:0] avs_writedata        = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rom_rd_valid;
    logic [47:0] rom_rd_offset;
    logic        rom_host_valid;
    logic [31:0] rom_host_addr;
    logic        post_fail;
    logic [47:0] post_fail_offset;
    logic [15:0] post_fail_source;
    logic        eeprom_id_valid;
    logic [63:0] eeprom_id_data;
    logic [31:0] rd_data;
    int          error_cnt            = 0;
    int          check_count          = 0;

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    // Byte enables tied: the block only takes full words
    ogr_regs #(.MAKER_CODE(MAKER_VAL)) u_ogr_regs
    (
        .mclk(mclk), .rst_n(rst_n), .pcie_reset_n(pcie_reset_n),
        .global_reset_input_n(global_reset_input_n), .por_n(por_n),
        .eeprom_present(eeprom_present), .eeprom_id_valid(eeprom_id_valid),
        .eeprom_id_data(eeprom_id_data), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rom_rd_valid(rom_rd_valid), .rom_rd_offset(rom_rd_offset),
        .rom_host_valid(rom_host_valid), .rom_host_addr(rom_host_addr),
        .post_fail(post_fail), .post_fail_offset(post_fail_offset),
        .post_fail_source(post_fail_source)
    );

    ogr_remote_node u_ogr_remote_node
    (
        .mclk(mclk), .rom_rd_valid(rom_rd_valid),
        .rom_rd_offset(rom_rd_offset), .post_fail(post_fail),
        .post_fail_offset(post_fail_offset),
        .post_fail_source(post_fail_source),
        .eeprom_id_valid(eeprom_id_valid), .eeprom_id_data(eeprom_id_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Bus cycle; waitrequest and read data taken at the rising edge only,
    // before that edge's own updates land, so both are the settled values
    task automatic avs_xfer(input logic wr, input logic [7:0] addr,
                            input logic [31:0] wdata,
                            output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address   <= addr;
        avs_writedata <= wdata;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do
        begin
            @(posedge mclk);
            n++;
            if (n > 20)
            begin
                error_cnt++;
                summarize();
            end
        end
        while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : avs_xfer

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        avs_xfer(1'b1, addr, data, rd_data);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] addr,
                          input logic [31:0] exp);
        avs_xfer(1'b0, addr, 32'h0000_0000, rd_data);
        chk(name, exp, rd_data);
    endtask : rd_chk

    task automatic id_chk(input logic [31:0] up, input logic [31:0] lo);
        rd_chk("uid_upper", ogr_pkg::ADDR_UID_UPPER, up);
        rd_chk("uid_lower", ogr_pkg::ADDR_UID_LOWER, lo);
    endtask : id_chk

    // Lower half is staged, the upper write commits and locks
    task automatic fw_load(input logic [31:0] up, input logic [31:0] lo);
        wr(ogr_pkg::ADDR_UID_LOWER, lo);
        wr(ogr_pkg::ADDR_UID_UPPER, up);
    endtask : fw_load

    task automatic rom_chk(input logic [47:0] off, input logic v,
                           input logic [31:0] a);
        u_ogr_remote_node.rom_read(off);
        @(negedge mclk);
        chk("rom_host_valid", {31'h0, v}, {31'h0, rom_host_valid});
        if (v)
            chk("rom_host_addr", a, rom_host_addr);
    endtask : rom_chk

    // Reset pins pass two sync flops, so hold and settle four edges each
    task automatic pin_pulse(input int i);
        @(posedge mclk);
        pcie_reset_n         <= (i != 0);
        global_reset_input_n <= (i != 1);
        por_n                <= (i != 2);
        repeat (4) @(posedge mclk);
        pcie_reset_n         <= 1'b1;
        global_reset_input_n <= 1'b1;
        por_n                <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : pin_pulse

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        id_chk(ogr_pkg::UID_RESET, ogr_pkg::UID_RESET);
        rd_chk("rom_map", ogr_pkg::ADDR_ROM_MAP_BASE, 32'h0000_0000);
        rd_chk("maker", ogr_pkg::ADDR_MAKER_ID, MAKER_VAL);
        rd_chk("unmapped", 8'h50, ogr_pkg::UNMAPPED_READ);
        wr(ogr_pkg::ADDR_MAKER_ID, 32'hffff_ffff);
        rd_chk("maker", ogr_pkg::ADDR_MAKER_ID, MAKER_VAL);
        wr(ogr_pkg::ADDR_ROM_MAP_BASE, 32'hffff_ffff);
        rd_chk("rom_map", ogr_pkg::ADDR_ROM_MAP_BASE, 32'hffff_fc00);
        $display("Test register access done");
        // Low base bits written as ones must not leak into the sum
        wr(ogr_pkg::ADDR_ROM_MAP_BASE, 32'h8000_0fff);
        rom_chk(48'hffff_f000_0400, 1'b1, 32'h8000_0c00);
        rom_chk(48'hffff_f000_07ff, 1'b1, 32'h8000_0fff);
        rom_chk(48'hffff_f000_0800, 1'b0, 32'h0000_0000);
        rom_chk(48'hffff_f000_03fc, 1'b0, 32'h0000_0000);
        $display("Test ROM window done");
        u_ogr_remote_node.fail_write(48'h1234_5678_9abc, 16'hfeed);
        rd_chk("fail_low", ogr_pkg::ADDR_FAIL_OFF_LOW, 32'h5678_9abc);
        rd_chk("fail_high", ogr_pkg::ADDR_FAIL_SRC_HI, 32'hfeed_1234);
        u_ogr_remote_node.fail_write(48'hffff_0000_0001, 16'h0040);
        rd_chk("fail_low", ogr_pkg::ADDR_FAIL_OFF_LOW, 32'h0000_0001);
        rd_chk("fail_high", ogr_pkg::ADDR_FAIL_SRC_HI, 32'h0040_ffff);
        rd_chk("status", ogr_pkg::ADDR_ID_STATUS, 32'h0000_0004);
        $display("Test failed write capture done");
        fw_load(32'habcd_0002, 32'hcafe_0001);
        id_chk(32'habcd_0002, 32'hcafe_0001);
        fw_load(32'h1111_1111, 32'h2222_2222);
        id_chk(32'habcd_0002, 32'hcafe_0001);
        for (int i = 0; i < 3; i++)
        begin
            pin_pulse(i);
            id_chk(32'h0000_0000, 32'h0000_0000);
            fw_load(32'h0000_0100 + 32'(i), 32'h0000_0200 + 32'(i));
            id_chk(32'h0000_0100 + 32'(i), 32'h0000_0200 + 32'(i));
        end
        $display("Test firmware load and reset pins done");
        // Mid-run system reset, then the EEPROM path
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        id_chk(32'h0000_0000, 32'h0000_0000);
        eeprom_present <= 1'b1;
        repeat (3) @(posedge mclk);
        fw_load(32'h3333_3333, 32'h4444_4444);
        id_chk(32'h0000_0000, 32'h0000_0000);
        u_ogr_remote_node.eeprom_load(64'h0123_4567_89ab_cdef);
        id_chk(32'h0123_4567, 32'h89ab_cdef);
        rd_chk("status", ogr_pkg::ADDR_ID_STATUS, 32'h0000_0003);
        u_ogr_remote_node.eeprom_load(64'h5555_5555_6666_6666);
        id_chk(32'h0123_4567, 32'h89ab_cdef);
        $display("Test EEPROM load done");
        summarize();
    end

    // Watchdog: the tests need well under 1000 cycles
    initial
    begin
        #50000;
        error_cnt++;
        summarize();
    end
endmodule : ogr_regs_tb
